// ### rtl/cafb_consts.svh
`ifndef CAFB_CONSTS_SVH
`define CAFB_CONSTS_SVH
// Functional notes
// - layout writable only in init mode
// - layout bits 5:4 select filter organization
// - closed layout accepts nothing, no reload
// - matched index bits 2:0 give filter
// - index updates when front buffer reloads
// - reset defaults to automatic bus-off recovery
// - user mode needs sequences and cleared hold
////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define CAFB_OFF_ACC 8'h00
`define CAFB_OFF_CTL 8'h04
`define CAFB_OFF_MISC 8'h08
`define CAFB_OFF_STAT 8'h0C
`define CAFB_OFF_INTST 8'h10
`define CAFB_OFF_INTMSK 8'h14
////////////////////////////////////////////////////////////////////////////////
// field positions
`define CAFB_ACC_LAYOUT_HI 5
`define CAFB_ACC_LAYOUT_LO 4
`define CAFB_ACC_HIT_HI 2
`define CAFB_ACC_HIT_LO 0
`define CAFB_CTL_INIT_REQUEST 0
`define CAFB_CTL_INIT_ACKNOWLEDGE 1
`define CAFB_CTL_RECSEL 2
`define CAFB_MISC_HOLD 0
`define CAFB_STAT_BUSOFF 0
`define CAFB_STAT_SEQDONE 1
`define CAFB_STAT_OCC_HI 15
`define CAFB_STAT_OCC_LO 8
`define CAFB_INT_LOADED 0
`define CAFB_INT_BOENTER 1
`define CAFB_INT_BOEXIT 2
`define CAFB_INT_NUM 3
////////////////////////////////////////////////////////////////////////////////
// reset values and counts
`define CAFB_RST_LAYOUT 2'h0
`define CAFB_RST_HIT 3'h0
`define CAFB_RST_RECSEL 1'h0
`define CAFB_RST_INT 3'h0
`define CAFB_RECESSIVE_RUN 4'hB
`define CAFB_OCC_TARGET 8'h80
`endif

// ### rtl/cafb_pkg.sv
package cafb_pkg;
  typedef enum logic [1:0] {
    CAFB_LAYOUT_TWO32 = 2'b00,
    CAFB_LAYOUT_FOUR16 = 2'b01,
    CAFB_LAYOUT_EIGHT8 = 2'b10,
    CAFB_LAYOUT_CLOSED = 2'b11
  } cafb_layout_type;
  typedef enum logic [1:0] {
    CAFB_ST_ACTIVE = 2'b00,
    CAFB_ST_BUSOFF = 2'b01
  } cafb_state_type;
endpackage

// ### rtl/cafb_busoff_if.sv
`timescale 1ns/1ps
interface cafb_busoff_if;
  logic bit_tick;
  logic rx_level;
  logic active;
  logic seq_done;
  logic [7:0] occ_count;
  modport ctrl (output bit_tick, output rx_level, output active,
                input seq_done, input occ_count);
  modport counter (input bit_tick, input rx_level, input active,
                   output seq_done, output occ_count);
endinterface

// ### rtl/cafb_sync.sv
`timescale 1ns/1ps
module cafb_sync import cafb_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'h1;
      s2_q <= 1'h1;
      s3_q <= 1'h1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once the two later stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'h1;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  assign level_out = level_q;
endmodule // cafb_sync

// ### rtl/cafb_busoff_cnt.sv
`timescale 1ns/1ps
`include "cafb_consts.svh"
module cafb_busoff_cnt import cafb_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link to the controller
  cafb_busoff_if.counter bl
);
  logic [3:0] run_q;
  logic [7:0] occ_q;

  // recessive runs of 11 bits, counted only while bus-off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 4'h0;
    end else if (!bl.active) begin
      run_q <= 4'h0;
    end else if (bl.bit_tick) begin
      if (!bl.rx_level) begin
        run_q <= 4'h0;
      end else if (run_q == `CAFB_RECESSIVE_RUN - 4'h1) begin
        run_q <= 4'h0;
      end else begin
        run_q <= run_q + 4'h1;
      end
    end
  end

  // saturates so a late hold release still finds the count met
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      occ_q <= 8'h00;
    end else if (!bl.active) begin
      occ_q <= 8'h00;
    end else if (bl.bit_tick && bl.rx_level && run_q == `CAFB_RECESSIVE_RUN - 4'h1
                 && occ_q != `CAFB_OCC_TARGET) begin
      occ_q <= occ_q + 8'h01;
    end
  end

  assign bl.occ_count = occ_q;
  assign bl.seq_done = (occ_q == `CAFB_OCC_TARGET);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_OCC_STEP: assert property ($changed(occ_q) && bl.active |->
    occ_q == $past(occ_q) + 8'h01 && $past(run_q) == `CAFB_RECESSIVE_RUN - 4'h1)
    else $error("occurrence count moved without an 11-bit run");
endmodule // cafb_busoff_cnt

// ### rtl/cafb_top.sv
`timescale 1ns/1ps
`include "cafb_consts.svh"
module cafb_top import cafb_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive fifo side
  input wire logic fifo_shift,
  input wire logic [2:0] fifo_hit_index,
  // can bus side
  input wire logic can_rx_pin,
  input wire logic bit_tick,
  input wire logic busoff_enter,
  // controller controls
  output logic accept_enable,
  output logic front_load,
  output logic [1:0] acceptance_layout,
  output logic tx_enable,
  output logic error_active,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = reg_hit(addr, `CAFB_OFF_ACC) || reg_hit(addr, `CAFB_OFF_CTL) ||
             reg_hit(addr, `CAFB_OFF_MISC) || reg_hit(addr, `CAFB_OFF_STAT) ||
             reg_hit(addr, `CAFB_OFF_INTST) || reg_hit(addr, `CAFB_OFF_INTMSK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  cafb_layout_type layout_q;
  logic [2:0] hit_q;
  logic init_req_q;
  logic init_ack_q;
  logic recov_sel_q;
  logic hold_q;
  cafb_state_type state_q;
  logic [`CAFB_INT_NUM-1:0] int_st_q;
  logic [`CAFB_INT_NUM-1:0] int_mask_q;
  logic [`CAFB_INT_NUM-1:0] ev;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic accept_q;
  logic front_load_q;
  logic tx_en_q;
  logic err_act_q;
  logic irq_q;
  logic rx_level;
  logic in_init;
  logic wr_acc;
  logic wr_ctl;
  logic wr_misc;
  logic wr_intst;
  logic wr_intmsk;
  logic load_now;
  logic recover_now;
  logic enter_now;

  cafb_busoff_if bl();

  ////////////////////////////////////////////////////////////////////////////
  // bus pin and bus-off counter
  cafb_sync u_rx_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(can_rx_pin),
    .level_out(rx_level)
  );

  assign bl.bit_tick = bit_tick;
  assign bl.rx_level = rx_level;
  assign bl.active = (state_q == CAFB_ST_BUSOFF);

  cafb_busoff_cnt u_busoff_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .bl(bl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb: zero-wait, answer in the access cycle
  logic access;
  assign access = psel && penable && pready_q;
  assign in_init = init_req_q && init_ack_q;
  assign wr_acc = access && pwrite && reg_hit(paddr, `CAFB_OFF_ACC);
  assign wr_ctl = access && pwrite && reg_hit(paddr, `CAFB_OFF_CTL);
  assign wr_misc = access && pwrite && reg_hit(paddr, `CAFB_OFF_MISC);
  assign wr_intst = access && pwrite && reg_hit(paddr, `CAFB_OFF_INTST);
  assign wr_intmsk = access && pwrite && reg_hit(paddr, `CAFB_OFF_INTMSK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !mapped(paddr);
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          `CAFB_OFF_ACC: begin
            prdata_q[`CAFB_ACC_LAYOUT_HI:`CAFB_ACC_LAYOUT_LO] <= layout_q;
            prdata_q[`CAFB_ACC_HIT_HI:`CAFB_ACC_HIT_LO] <= hit_q;
          end
          `CAFB_OFF_CTL: begin
            prdata_q[`CAFB_CTL_INIT_REQUEST] <= init_req_q;
            prdata_q[`CAFB_CTL_INIT_ACKNOWLEDGE] <= init_ack_q;
            prdata_q[`CAFB_CTL_RECSEL] <= recov_sel_q;
          end
          `CAFB_OFF_MISC: begin
            prdata_q[`CAFB_MISC_HOLD] <= hold_q;
          end
          `CAFB_OFF_STAT: begin
            prdata_q[`CAFB_STAT_BUSOFF] <= (state_q == CAFB_ST_BUSOFF);
            prdata_q[`CAFB_STAT_SEQDONE] <= bl.seq_done;
            prdata_q[`CAFB_STAT_OCC_HI:`CAFB_STAT_OCC_LO] <= bl.occ_count;
          end
          `CAFB_OFF_INTST: begin
            prdata_q[`CAFB_INT_NUM-1:0] <= int_st_q;
          end
          `CAFB_OFF_INTMSK: begin
            prdata_q[`CAFB_INT_NUM-1:0] <= int_mask_q;
          end
          default: begin
            prdata_q <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register and init handshake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_req_q <= 1'h0;
      recov_sel_q <= `CAFB_RST_RECSEL;
    end else if (wr_ctl) begin
      init_req_q <= pwdata[`CAFB_CTL_INIT_REQUEST];
      recov_sel_q <= pwdata[`CAFB_CTL_RECSEL];
    end
  end

  // acknowledge follows the request one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_ack_q <= 1'h0;
    end else begin
      init_ack_q <= init_req_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acceptance layout and matched index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      layout_q <= cafb_layout_type'(`CAFB_RST_LAYOUT);
    end else if (wr_acc && in_init) begin
      layout_q <= cafb_layout_type'(pwdata[`CAFB_ACC_LAYOUT_HI:`CAFB_ACC_LAYOUT_LO]);
    end
  end

  // closed layout blocks every reload of the front buffer
  assign load_now = fifo_shift && (layout_q != CAFB_LAYOUT_CLOSED);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_q <= `CAFB_RST_HIT;
    end else if (load_now) begin
      hit_q <= fifo_hit_index;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accept_q <= 1'h0;
      front_load_q <= 1'h0;
    end else begin
      accept_q <= (layout_q != CAFB_LAYOUT_CLOSED);
      front_load_q <= load_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus-off recovery
  assign enter_now = (state_q == CAFB_ST_ACTIVE) && busoff_enter;
  assign recover_now = (state_q == CAFB_ST_BUSOFF) && bl.seq_done &&
                       (!recov_sel_q || !hold_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= CAFB_ST_ACTIVE;
    end else begin
      case (state_q)
        CAFB_ST_ACTIVE: begin
          if (busoff_enter) begin
            state_q <= CAFB_ST_BUSOFF;
          end
        end
        CAFB_ST_BUSOFF: begin
          if (recover_now) begin
            state_q <= CAFB_ST_ACTIVE;
          end
        end
        default: begin
          state_q <= CAFB_ST_ACTIVE;
        end
      endcase
    end
  end

  // hold set by bus-off entry wins over a same-cycle software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'h0;
    end else if (enter_now && recov_sel_q) begin
      hold_q <= 1'h1;
    end else if (wr_misc && pwdata[`CAFB_MISC_HOLD]) begin
      hold_q <= 1'h0;
    end
  end

  // transmitter dropped in the same edge that enters bus-off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en_q <= 1'h0;
      err_act_q <= 1'h0;
    end else begin
      tx_en_q <= (state_q == CAFB_ST_ACTIVE) ? !busoff_enter : recover_now;
      err_act_q <= (state_q == CAFB_ST_ACTIVE) ? !busoff_enter : recover_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, set wins
  assign ev[`CAFB_INT_LOADED] = load_now;
  assign ev[`CAFB_INT_BOENTER] = enter_now;
  assign ev[`CAFB_INT_BOEXIT] = recover_now;

  genvar gi;
  generate
    for (gi = 0; gi < `CAFB_INT_NUM; gi++) begin : g_int
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          int_st_q[gi] <= 1'h0;
        end else if (ev[gi]) begin
          int_st_q[gi] <= 1'h1;
        end else if (wr_intst && pwdata[gi]) begin
          int_st_q[gi] <= 1'h0;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_q <= `CAFB_RST_INT;
    end else if (wr_intmsk) begin
      int_mask_q <= pwdata[`CAFB_INT_NUM-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'h0;
    end else begin
      irq_q <= |(int_st_q & int_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign accept_enable = accept_q;
  assign front_load = front_load_q;
  assign acceptance_layout = layout_q;
  assign tx_enable = tx_en_q;
  assign error_active = err_act_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LAYOUT_LOCK: assert property (!(init_req_q && init_ack_q) |=> $stable(layout_q))
    else $error("layout changed outside init mode");

  AST_LAYOUT_WRITE: assert property (wr_acc && in_init |=>
    layout_q == $past(pwdata[`CAFB_ACC_LAYOUT_HI:`CAFB_ACC_LAYOUT_LO]))
    else $error("layout write in init mode not taken");

  AST_CLOSED_NO_LOAD: assert property (layout_q == CAFB_LAYOUT_CLOSED |=>
    !front_load_q && !accept_q)
    else $error("front buffer reloaded with filter closed");

  AST_HIT_CAPTURE: assert property (load_now |=>
    hit_q == $past(fifo_hit_index) && front_load_q)
    else $error("matched index not captured on reload");

  AST_HIT_STABLE: assert property (!load_now |=> $stable(hit_q))
    else $error("matched index moved without a reload");

  AST_AUTO_RECOVER: assert property (state_q == CAFB_ST_BUSOFF && bl.seq_done &&
    !recov_sel_q |=> state_q == CAFB_ST_ACTIVE && tx_en_q)
    else $error("automatic recovery did not happen");

  AST_USER_WAIT: assert property (state_q == CAFB_ST_BUSOFF && recov_sel_q &&
    (hold_q || !bl.seq_done) |=> state_q == CAFB_ST_BUSOFF)
    else $error("user recovery left bus-off early");

  AST_TX_OFF: assert property (state_q == CAFB_ST_BUSOFF |-> !tx_en_q && !err_act_q)
    else $error("transmitter enabled during bus-off");

  AST_HOLD_SET: assert property (enter_now && recov_sel_q |=> hold_q ##1
    (hold_q || $past(wr_misc && pwdata[`CAFB_MISC_HOLD]))) else $error("hold not kept after bus-off entry");

  AST_IRQ_LEVEL: assert property (|(int_st_q & int_mask_q) |=> irq_q)
    else $error("interrupt not raised for unmasked status");
endmodule // cafb_top

// ### tb/cafb_bus_model.sv
`timescale 1ns/1ps
module cafb_bus_model #(
  parameter int GAP = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // traffic control
  input wire logic run,
  input wire logic [3:0] dom_bits,
  // bus side
  output logic bit_tick,
  output logic can_rx_pin
);
  logic [3:0] div_q;
  logic [3:0] dom_q;

  ////////////////////////////////////////////////////////////////////////////////
  // idle bus rests recessive through the termination only while dom_bits is zero, else dominant; sample points stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 4'h0;
      dom_q <= 4'h0;
      bit_tick <= 1'b0;
      can_rx_pin <= 1'b1;
    end else if (!run) begin
      div_q <= 4'h0;
      bit_tick <= 1'b0;
      dom_q <= dom_bits;
      can_rx_pin <= (dom_bits == 4'h0);
    end else begin
      bit_tick <= (div_q == GAP[3:0]);
      div_q <= (div_q == GAP[3:0]) ? 4'h0 : div_q + 4'h1;
      if (bit_tick) begin
        // level moves just after a sample point, so it is settled long before the next
        dom_q <= (dom_q == 4'h0) ? 4'h0 : dom_q - 4'h1;
        can_rx_pin <= (dom_q <= 4'h1);
      end
    end
  end
endmodule // cafb_bus_model

// ### tb/tb.sv
`timescale 1ns/1ps
`include "cafb_consts.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb import cafb_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic errv, fifo_shift, can_rx_pin, bit_tick, busoff_enter, run;
  logic [2:0] fifo_hit_index;
  logic [3:0] dom_bits;
  logic accept_enable, front_load, tx_enable, error_active, irq;
  logic [1:0] acceptance_layout;
  int errors, num_checks;
  int tick_cnt = 0;

  cafb_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fifo_shift(fifo_shift), .fifo_hit_index(fifo_hit_index),
    .can_rx_pin(can_rx_pin), .bit_tick(bit_tick), .busoff_enter(busoff_enter),
    .accept_enable(accept_enable), .front_load(front_load),
    .acceptance_layout(acceptance_layout), .tx_enable(tx_enable),
    .error_active(error_active), .irq(irq));
  cafb_bus_model i_bus (.pclk(pclk), .presetn(presetn), .run(run), .dom_bits(dom_bits),
    .bit_tick(bit_tick), .can_rx_pin(can_rx_pin));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (run === 1'b1 && bit_tick === 1'b1) begin
      tick_cnt <= tick_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("errors=%0d num_checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request held until the rising edge that sees pready, answer taken there
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      errors++;
      stop_test();
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK(rdv, e)
    `CHK(errv, ee)
  endtask

  task automatic shift(input logic [2:0] i, input logic exp_load);
    @(posedge pclk);
    fifo_shift <= 1'b1;
    fifo_hit_index <= i;
    @(posedge pclk);
    fifo_shift <= 1'b0;
    @(negedge pclk);
    `CHK(front_load, exp_load)
  endtask

  task automatic enter();
    @(posedge pclk);
    busoff_enter <= 1'b1;
    @(posedge pclk);
    busoff_enter <= 1'b0;
    @(negedge pclk);
    `CHK(tx_enable, 1'b0)
  endtask

  task automatic run_ticks(input int n);
    int k;
    int base;
    k = 0;
    base = tick_cnt;
    @(posedge pclk);
    run <= 1'b1;
    while (tick_cnt - base < n && k < 20000) begin
      @(negedge pclk);
      k++;
    end
    if (k >= 20000) begin
      errors++;
      stop_test();
    end
    @(posedge pclk);
    run <= 1'b0;
  endtask

  task automatic wait_active(input int lim);
    int k;
    k = 0;
    while (error_active !== 1'b1 && k < lim) begin
      @(negedge pclk);
      k++;
    end
    `CHK(error_active, 1'b1)
    `CHK(tx_enable, 1'b1)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, fifo_shift, busoff_enter, run} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    fifo_hit_index = 3'h0;
    dom_bits = 4'h0;
    errors = 0;
    num_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`CAFB_OFF_ACC, 32'h0, 1'b0);
    rchk(`CAFB_OFF_CTL, 32'h0, 1'b0);
    rchk(`CAFB_OFF_MISC, 32'h0, 1'b0);
    rchk(8'h18, 32'h0, 1'b1);
    `CHK(tx_enable, 1'b1)
    // layout stays locked outside init mode
    wr(`CAFB_OFF_ACC, 32'h20);
    rchk(`CAFB_OFF_ACC, 32'h0, 1'b0);
    wr(`CAFB_OFF_CTL, 32'h1);
    rchk(`CAFB_OFF_CTL, 32'h3, 1'b0);
    for (int l = 0; l < 4; l++) begin
      wr(`CAFB_OFF_ACC, {26'h0, l[1:0], 4'h7});
      rchk(`CAFB_OFF_ACC, {26'h0, l[1:0], 4'h0}, 1'b0);
      `CHK(acceptance_layout, l[1:0])
      `CHK(accept_enable, (l != 3))
    end
    wr(`CAFB_OFF_CTL, 32'h0);
    wr(`CAFB_OFF_ACC, 32'h10);
    `CHK(acceptance_layout, CAFB_LAYOUT_CLOSED)
    wr(`CAFB_OFF_INTMSK, 32'h1);
    shift(3'h5, 1'b0);
    rchk(`CAFB_OFF_ACC, 32'h30, 1'b0);
    rchk(`CAFB_OFF_INTST, 32'h0, 1'b0);
    wr(`CAFB_OFF_CTL, 32'h1);
    wr(`CAFB_OFF_ACC, 32'h10);
    wr(`CAFB_OFF_CTL, 32'h0);
    for (int i = 7; i >= 0; i--) begin
      shift(i[2:0], 1'b1);
      rchk(`CAFB_OFF_ACC, {28'h1, 1'b0, i[2:0]}, 1'b0);
    end
    `CHK(irq, 1'b1)
    wr(`CAFB_OFF_INTST, 32'h1);
    rchk(`CAFB_OFF_INTST, 32'h0, 1'b0);
    `CHK(irq, 1'b0)
    // two messages back to back, the later one owns the index
    @(posedge pclk);
    fifo_shift <= 1'b1;
    fifo_hit_index <= 3'h2;
    @(posedge pclk);
    fifo_hit_index <= 3'h6;
    @(posedge pclk);
    fifo_shift <= 1'b0;
    rchk(`CAFB_OFF_ACC, 32'h16, 1'b0);
    wr(`CAFB_OFF_INTMSK, 32'h2);
    wr(`CAFB_OFF_INTST, 32'h7);
    // automatic recovery, two dominant bits first restart the run
    enter();
    dom_bits <= 4'h2;
    rchk(`CAFB_OFF_INTST, 32'h2, 1'b0);
    `CHK(irq, 1'b1)
    run_ticks(1409);
    rchk(`CAFB_OFF_STAT, 32'h7F01, 1'b0);
    `CHK(error_active, 1'b0)
    dom_bits <= 4'h0;
    run_ticks(1);
    wait_active(8);
    rchk(`CAFB_OFF_STAT, 32'h0, 1'b0);
    rchk(`CAFB_OFF_INTST, 32'h6, 1'b0);
    wr(`CAFB_OFF_INTST, 32'h7);
    // user request, hold released after the sequences
    wr(`CAFB_OFF_CTL, 32'h4);
    rchk(`CAFB_OFF_CTL, 32'h4, 1'b0);
    enter();
    rchk(`CAFB_OFF_MISC, 32'h1, 1'b0);
    run_ticks(1408);
    repeat (20) @(negedge pclk);
    `CHK(error_active, 1'b0)
    rchk(`CAFB_OFF_STAT, 32'h8003, 1'b0);
    wr(`CAFB_OFF_MISC, 32'h1);
    wait_active(8);
    // user request, hold released before the sequences
    enter();
    wr(`CAFB_OFF_MISC, 32'h1);
    rchk(`CAFB_OFF_MISC, 32'h0, 1'b0);
    run_ticks(1407);
    rchk(`CAFB_OFF_STAT, 32'h7F01, 1'b0);
    `CHK(error_active, 1'b0)
    run_ticks(1);
    wait_active(8);
    stop_test();
  end
endmodule // tb
